// ---- hw/psd_regs.vh ----
`ifndef PSD_REGS_VH
`define PSD_REGS_VH
// Serial access lengths in clocks
`define PSD_LEN_CFG 5'd8
`define PSD_LEN_REF 5'd16
`define PSD_LEN_DIV 5'd24
// Configuration byte fields
`define PSD_CFG_INVERT 7
`define PSD_CFG_PDA 6
`define PSD_CFG_STEP 1
`define PSD_CFG_CUR_HI 3
`define PSD_CFG_CUR_LO 2
`define PSD_CFG_RESET 8'h00
// Reference register fields
`define PSD_REF_OPT_HI 15
`define PSD_REF_OPT_LO 13
`define PSD_REF_RATIO_HI 12
`define PSD_REF_RATIO_LO 0
// Power-on defaults: option code gives reference output ratio of eight
`define PSD_REF_OPT_RESET 3'h4
`define PSD_REF_RATIO_RESET 13'h0001
// Divider register fields
`define PSD_DIV_SWALLOW_HI 6
`define PSD_DIV_MAIN_HI 18
`define PSD_DIV_MAIN_LO 7
`define PSD_DIV_OUTA_HI 23
`define PSD_DIV_OUTA_LO 22
`define PSD_DIV_RESET 24'h000000
`define PSD_OUTA_DATA_OUT 2'h0
`define PSD_OUTA_PORT 2'h3
// Prescaler base modulus
`define PSD_PRESCALE 7'd64
// In-phase dual-drive pulse length, ns, and cycles at 40 MHz
`define PSD_DUAL_NS 50
`define PSD_CLK_NS 25
`define PSD_DUAL_CYC ((`PSD_DUAL_NS + `PSD_CLK_NS - 1) / `PSD_CLK_NS)
`endif

// ---- hw/psd_sync.v ----
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for one pin level
module psd_sync (
   // Clock and reset
   input wire clk,
   input wire resetn,
   // Level in and out
   input wire din,
   output reg dout
);
   reg meta_reg; // First stage, read only by dout

   // Two stages of resampling
   always @(posedge clk) begin
      if (!resetn) begin
         meta_reg <= 1'b0;
         dout <= 1'b0;
      end else begin
         meta_reg <= din;
         dout <= meta_reg;
      end
   end
endmodule // psd_sync
`default_nettype wire

// ---- hw/psd_top.v ----
`timescale 1ns/1ps
`default_nettype none
`include "psd_regs.vh"
// How it works
// - Step low: codes give 70..100 percent
// - Step high, output A not in port mode: codes give 25..100 percent
// - Feedback divides main times 64 plus swallow
// - Divider write also copies ratio buffer
// - Output A powers up as data out
// - Top three reference bits set options
// - Low thirteen bits set reference ratio
// - Power-on reference output ratio eight
// - Reference write: options now, ratio buffered
// - Enable pulse loads ratio at cycle end
// - Sixteen clocks select reference register
// - Pump drives when unlocked, floats locked
// - In phase, both drivers pulse briefly
// - Step bit chooses 10 or 25 percent; port mode on output A forces 10
// - Eight clocks select configuration register
module psd_top (
   // System
   input wire clk,
   input wire resetn,
   // Serial port pins
   input wire ser_clk,
   input wire ser_data,
   input wire ser_enable,
   output reg data_out,
   // Reference and feedback clocks
   input wire reference_input,
   input wire prescaler_in,
   output reg reference_output,
   output wire modulus_ctl,
   // Charge pump
   output reg pump_up,
   output reg pump_down,
   output reg [6:0] pump_current_pct,
   output wire charge_pump_out_oe,
   // Output A and compare strobes
   output reg output_a,
   output reg reference_compare_freq,
   output reg feedback_compare_freq
);
   // Synchronised pins
   wire sclk_s, sdat_s, sen_s, ref_s, pre_s;
   psd_sync u_s0 (.clk(clk), .resetn(resetn), .din(ser_clk), .dout(sclk_s));
   psd_sync u_s1 (.clk(clk), .resetn(resetn), .din(ser_data), .dout(sdat_s));
   psd_sync u_s2 (.clk(clk), .resetn(resetn), .din(ser_enable), .dout(sen_s));
   psd_sync u_s3 (.clk(clk), .resetn(resetn), .din(reference_input), .dout(ref_s));
   psd_sync u_s4 (.clk(clk), .resetn(resetn), .din(prescaler_in), .dout(pre_s));

   // Edge history
   reg sclk_d_reg, sen_d_reg, ref_d_reg, pre_d_reg;
   reg enable_seen_clk_reg; // Any clock rise during this enable window
   wire sclk_rise = sclk_s & ~sclk_d_reg;
   wire sen_rise = sen_s & ~sen_d_reg;
   wire sen_fall = ~sen_s & sen_d_reg;
   wire ref_rise = ref_s & ~ref_d_reg;
   wire pre_rise = pre_s & ~pre_d_reg;

   // Shift path and registers
   reg [23:0] shift_reg;
   reg [4:0] bit_cnt_reg; // Saturates at 31
   reg [7:0] cfg_reg;
   reg [2:0] ref_opt_reg;
   reg [12:0] ratio_buf1_reg; // First buffer
   reg [12:0] ratio_buf2_reg; // Second buffer, counter source
   reg [23:0] div_pend_reg; // Written, awaiting a safe point
   reg div_pend_valid_reg;
   reg [23:0] div_reg; // Active divider word
   wire div_take; // Pending word taken at a feedback reload

   // Shift in on serial clock rises while enabled, count the clocks
   always @(posedge clk) begin
      if (!resetn) begin
         shift_reg <= 24'h000000;
         bit_cnt_reg <= 5'd0;
         data_out <= 1'b0;
         enable_seen_clk_reg <= 1'b0;
      end else if (sen_rise) begin
         bit_cnt_reg <= 5'd0;
         enable_seen_clk_reg <= 1'b0;
      end else if (sen_s && sclk_rise) begin
         shift_reg <= {shift_reg[22:0], sdat_s};
         data_out <= shift_reg[23]; // Cascade out
         enable_seen_clk_reg <= 1'b1;
         if (bit_cnt_reg != 5'd31) begin
            bit_cnt_reg <= bit_cnt_reg + 5'd1;
         end
      end
   end

   // Option and ratio update flags for the counters
   reg ratio_load_pend_reg; // Second buffer waiting for cycle end
   reg [12:0] ratio_next_buf2;

   // Register transfer on enable release
   always @(posedge clk) begin
      if (!resetn) begin
         cfg_reg <= `PSD_CFG_RESET;
         ref_opt_reg <= `PSD_REF_OPT_RESET;
         ratio_buf1_reg <= `PSD_REF_RATIO_RESET;
         ratio_buf2_reg <= `PSD_REF_RATIO_RESET;
         div_pend_reg <= `PSD_DIV_RESET;
         div_pend_valid_reg <= 1'b0;
      end else begin
         if (sen_fall && bit_cnt_reg == `PSD_LEN_CFG) begin
            cfg_reg <= shift_reg[7:0];
         end else if (sen_fall && bit_cnt_reg == `PSD_LEN_REF) begin
            ref_opt_reg <= shift_reg[`PSD_REF_OPT_HI:`PSD_REF_OPT_LO];
            ratio_buf1_reg <= shift_reg[`PSD_REF_RATIO_HI:`PSD_REF_RATIO_LO];
         end else if (sen_fall && bit_cnt_reg == `PSD_LEN_DIV) begin
            div_pend_reg <= shift_reg;
            div_pend_valid_reg <= 1'b1;
            ratio_buf2_reg <= ratio_buf1_reg;
         end else if (sen_fall && !enable_seen_clk_reg) begin
            // Bare enable pulse with clock held low loads second buffer
            ratio_buf2_reg <= ratio_buf1_reg;
         end
         // Pending divider word clears once taken at a reload
         if (div_take) begin
            div_pend_valid_reg <= 1'b0;
         end
      end
   end

   // Reference divider: counter takes new ratio only on wrap
   reg [12:0] ref_cnt_reg;
   reg [12:0] ref_ratio_reg; // Ratio in use this cycle
   reg [2:0] pre_div_reg; // Three-stage divider for reference output
   wire ref_wrap = ref_rise && (ref_cnt_reg <= 13'd1);
   always @(posedge clk) begin
      if (!resetn) begin
         ref_cnt_reg <= `PSD_REF_RATIO_RESET;
         ref_ratio_reg <= `PSD_REF_RATIO_RESET;
         reference_compare_freq <= 1'b0;
         pre_div_reg <= 3'h0;
         reference_output <= 1'b0;
      end else begin
         reference_compare_freq <= ref_wrap;
         if (ref_rise) begin
            pre_div_reg <= pre_div_reg + 3'h1;
            if (ref_wrap) begin
               ref_ratio_reg <= ratio_buf2_reg;
               ref_cnt_reg <= ratio_buf2_reg;
            end else begin
               ref_cnt_reg <= ref_cnt_reg - 13'd1;
            end
         end
         // Option code selects output: low, in/1, in/2, in/4, in/8
         case (ref_opt_reg)
            3'h0: reference_output <= 1'b0;
            3'h1: reference_output <= ref_s;
            3'h2: reference_output <= pre_div_reg[0];
            3'h3: reference_output <= pre_div_reg[1];
            default: reference_output <= pre_div_reg[2];
         endcase
      end
   end

   // Feedback divider: main count times 64 plus swallow count
   reg [11:0] main_cnt_reg;
   reg [5:0] swallow_cnt_reg;
   reg [6:0] pre_cnt_reg; // Models the 64/65 prescaler
   wire [6:0] pre_mod = swallow_cnt_reg != 6'd0 ? `PSD_PRESCALE + 7'd1 : `PSD_PRESCALE;
   wire pre_out = pre_rise && (pre_cnt_reg >= pre_mod - 7'd1);
   wire fb_reload = pre_out && (main_cnt_reg <= 12'd1);
   assign div_take = div_pend_valid_reg && fb_reload;
   wire [23:0] div_use = div_take ? div_pend_reg : div_reg;
   assign modulus_ctl = (swallow_cnt_reg == 6'd0);
   always @(posedge clk) begin
      if (!resetn) begin
         div_reg <= `PSD_DIV_RESET;
         main_cnt_reg <= 12'd0;
         swallow_cnt_reg <= 6'd0;
         pre_cnt_reg <= 7'd0;
         feedback_compare_freq <= 1'b0;
      end else begin
         feedback_compare_freq <= fb_reload;
         if (div_take) begin
            div_reg <= div_pend_reg;
         end
         if (pre_rise) begin
            pre_cnt_reg <= pre_out ? 7'd0 : pre_cnt_reg + 7'd1;
         end
         if (fb_reload) begin
            // Reload both counters together; host keeps main >= swallow
            main_cnt_reg <= div_use[`PSD_DIV_MAIN_HI:`PSD_DIV_MAIN_LO];
            swallow_cnt_reg <= div_use[`PSD_DIV_SWALLOW_HI-1:0];
         end else if (pre_out) begin
            main_cnt_reg <= main_cnt_reg - 12'd1;
            if (swallow_cnt_reg != 6'd0) begin
               swallow_cnt_reg <= swallow_cnt_reg - 6'd1;
            end
         end
      end
   end

   // Current setting from the configuration byte
   wire [1:0] cur_code = {cfg_reg[`PSD_CFG_CUR_HI], cfg_reg[`PSD_CFG_CUR_LO]};
   wire outa_port = (div_reg[`PSD_DIV_OUTA_HI:`PSD_DIV_OUTA_LO] == `PSD_OUTA_PORT);
   always @(posedge clk) begin
      if (!resetn) begin
         pump_current_pct <= 7'd70;
         output_a <= 1'b0;
      end else begin
         if (cfg_reg[`PSD_CFG_STEP] && !outa_port) begin
            pump_current_pct <= 7'd25 + 7'd25 * {5'h00, cur_code};
         end else begin
            pump_current_pct <= 7'd70 + 7'd10 * {5'h00, cur_code};
         end
         // Port mode drives the step bit out, else serial data out
         output_a <= outa_port ? cfg_reg[`PSD_CFG_STEP] : data_out;
      end
   end

   // Phase/frequency detector; both drivers on briefly when in phase
   reg up_reg, dn_reg;
   reg [3:0] dual_cnt_reg;
   wire both = up_reg & dn_reg;
   always @(posedge clk) begin
      if (!resetn) begin
         up_reg <= 1'b0;
         dn_reg <= 1'b0;
         dual_cnt_reg <= 4'h0;
         pump_up <= 1'b0;
         pump_down <= 1'b0;
      end else begin
         if (both && dual_cnt_reg >= `PSD_DUAL_CYC - 1) begin
            up_reg <= 1'b0; // Reset after dual interval
            dn_reg <= 1'b0;
            dual_cnt_reg <= 4'h0;
         end else begin
            if (reference_compare_freq) up_reg <= 1'b1;
            if (feedback_compare_freq) dn_reg <= 1'b1;
            dual_cnt_reg <= both ? dual_cnt_reg + 4'h1 : 4'h0;
         end
         // Polarity bit swaps source and sink
         pump_up <= cfg_reg[`PSD_CFG_INVERT] ? dn_reg : up_reg;
         pump_down <= cfg_reg[`PSD_CFG_INVERT] ? up_reg : dn_reg;
      end
   end
   // Floats when neither drives or detector A disabled
   assign charge_pump_out_oe = cfg_reg[`PSD_CFG_PDA] & (pump_up | pump_down);

   // Clock history registers
   always @(posedge clk) begin
      if (!resetn) begin
         sclk_d_reg <= 1'b0;
         sen_d_reg <= 1'b0;
         ref_d_reg <= 1'b0;
         pre_d_reg <= 1'b0;
      end else begin
         sclk_d_reg <= sclk_s;
         sen_d_reg <= sen_s;
         ref_d_reg <= ref_s;
         pre_d_reg <= pre_s;
      end
   end
endmodule // psd_top
`default_nettype wire

// ---- verification/psd_top_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the synthesizer control block
module psd_top_sva (
   // System
   input wire logic clk,
   input wire logic resetn,
   // Serial enable pin
   input wire logic ser_enable,
   // Watched outputs
   input wire logic pump_up,
   input wire logic pump_down,
   input wire logic [6:0] pump_current_pct,
   input wire logic charge_pump_out_oe,
   input wire logic output_a,
   input wire logic reference_compare_freq,
   input wire logic feedback_compare_freq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   pct_legal_a: assert property (
      pump_current_pct inside {7'h19, 7'h32, 7'h46, 7'h4b, 7'h50, 7'h5a, 7'h64})
      else $error("pump current off table");
   pct_update_a: assert property (
      !$stable(pump_current_pct) |-> !ser_enable && !$past(ser_enable, 2))
      else $error("current changed mid frame");
   pct_hold_a: assert property ($fell(ser_enable) |-> $stable(pump_current_pct) [*2])
      else $error("current changed too early");
   oe_drive_a: assert property (charge_pump_out_oe |-> pump_up || pump_down)
      else $error("pump enabled without drive");
   dual_pulse_a: assert property (
      $rose(pump_up && pump_down) |=> (pump_up && pump_down) ##1 !(pump_up && pump_down))
      else $error("dual drive length wrong");
   fr_gap_a: assert property (reference_compare_freq |=> !reference_compare_freq [*4])
      else $error("reference strobe too close");
   fv_gap_a: assert property (feedback_compare_freq |=> !feedback_compare_freq [*4])
      else $error("feedback strobe too close");
   reset_vals_a: assert property (
      $rose(resetn) |-> pump_current_pct == 7'h46 && !output_a && !pump_up && !pump_down)
      else $error("bad value after reset");
endmodule // psd_top_sva
`default_nettype wire

// ---- verification/psd_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// Host model; serial clock stands low outside frames
module psd_host (
   // Pacing clock
   input wire logic clk,
   // Serial pins
   output logic ser_clk,
   output logic ser_data,
   output logic ser_enable
);
   initial begin
      ser_clk = 1'b0;
      ser_data = 1'b0;
      ser_enable = 1'b0;
   end
   // MSB first, 200 ns clock; n of 0 is a bare load pulse, clock held low
   task automatic send(input logic [23:0] word, input int n);
      repeat (4) @(negedge clk);
      ser_enable = 1'b1;
      for (int i = n - 1; i >= 0; i--) begin
         ser_data = word[i];
         repeat (4) @(negedge clk);
         ser_clk = 1'b1;
         repeat (4) @(negedge clk);
         ser_clk = 1'b0;
      end
      repeat (4) @(negedge clk);
      ser_enable = 1'b0;
      // Released data line must not keep its last level
      ser_data = ~ser_data;
      repeat (12) @(negedge clk);
   endtask
endmodule // psd_host
`default_nettype wire

// ---- verification/psd_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module psd_top_tb;
   logic clk, resetn, ser_clk, ser_data, ser_enable, reference_input, prescaler_in;
   logic data_out, reference_output, modulus_ctl, pump_up, pump_down, charge_pump_out_oe;
   logic output_a, reference_compare_freq, feedback_compare_freq;
   logic ro_q = 1'b0;
   logic [6:0] pump_current_pct;
   int error_cnt = 0, n_checks = 0, cycles = 0, fr_n = 0, ro_n = 0, fv_n = 0, a, b;
   psd_top i_psd_top (.clk, .resetn, .ser_clk, .ser_data, .ser_enable, .data_out,
      .reference_input, .prescaler_in, .reference_output, .modulus_ctl, .pump_up,
      .pump_down, .pump_current_pct, .charge_pump_out_oe, .output_a,
      .reference_compare_freq, .feedback_compare_freq);
   psd_host i_psd_host (.clk, .ser_clk, .ser_data, .ser_enable);
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Free-running input clocks, edges on rising clk
   initial begin
      reference_input = 1'b0;
      #12.5;
      forever #200 reference_input = ~reference_input;
   end
   initial begin
      prescaler_in = 1'b0;
      #12.5;
      forever #300 prescaler_in = ~prescaler_in;
   end
   // Running counts of strobes and output rises
   always @(posedge clk) begin
      cycles <= cycles + 1;
      ro_q <= reference_output;
      fr_n <= fr_n + reference_compare_freq;
      fv_n <= fv_n + feedback_compare_freq;
      ro_n <= ro_n + (reference_output & ~ro_q);
      if (cycles == 60000) begin
         error_cnt++;
         stop_test();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   // Counts over 32 reference edges, after settling
   task automatic rates(output int fr, output int ro);
      int f0, r0;
      repeat (12) @(posedge reference_input);
      f0 = fr_n;
      r0 = ro_n;
      repeat (32) @(posedge reference_input);
      fr = fr_n - f0;
      ro = ro_n - r0;
   endtask
   task automatic t_power;
      rates(a, b);
      check(b, 4);
      check(a, 32);
      check(output_a, 1'b0);
      $display("power-on test done");
   endtask
   task automatic t_current;
      for (int s = 0; s < 2; s++)
         for (int c = 0; c < 4; c++) begin
            i_psd_host.send({16'h0, 4'h4, c[1:0], s[0], 1'b0}, 8);
            check(pump_current_pct, s ? 7'h19 * (c + 1) : 7'h46 + 7'ha * c);
         end
      // Twelve clocks are ignored
      i_psd_host.send(24'h000040, 12);
      check(pump_current_pct, 7'h64);
      // Three groups of five clocks leave the registers alone
      repeat (3) i_psd_host.send(24'h0, 5);
      check(pump_current_pct, 7'h64);
      // Cascade output follows the shifter's top bit
      for (int v = 0; v < 2; v++) begin
         repeat (3) i_psd_host.send(v ? 24'hfff : 24'h0, 12);
         check(data_out, v);
         check(output_a, v);
      end
      $display("current test done");
   endtask
   task automatic t_ref;
      for (int o = 0; o < 5; o++) begin
         i_psd_host.send({8'h0, o[2:0], 13'h4}, 16);
         rates(a, b);
         check(b, o == 0 ? 0 : o > 3 ? 4 : 32 >> (o - 1));
         check(a, 32);
      end
      i_psd_host.send(24'h0, 0);
      rates(a, b);
      check(a, 8);
      i_psd_host.send(24'h8002, 16);
      i_psd_host.send(24'hc00282, 24);
      rates(a, b);
      check(a, 16);
      check(b, 4);
      check(pump_current_pct, 7'h64);
      $display("reference test done");
   endtask
   task automatic t_div;
      int v0, n;
      // Let the pending word be taken, then time one full period
      repeat (2) begin
         v0 = fv_n;
         while (fv_n == v0) @(posedge clk);
      end
      v0 = fv_n;
      n = 0;
      a = 0;
      while (fv_n == v0 && n < 400) begin
         @(posedge prescaler_in);
         n++;
         a += !modulus_ctl;
         repeat (8) @(posedge clk);
      end
      check(n, 322);
      check(a, 130);
      i_psd_host.send(24'h4e, 8);
      check(output_a, 1'b1);
      check(pump_current_pct, 7'h64);
      i_psd_host.send(24'h44, 8);
      check(output_a, 1'b0);
      check(pump_current_pct, 7'h50);
      $display("divider test done");
   endtask
   task automatic stop_test;
      $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      resetn = 1'b0;
      repeat (12) @(negedge clk);
      resetn = 1'b1;
      t_power();
      t_current();
      t_ref();
      t_div();
      stop_test();
   end
endmodule // psd_top_tb
bind psd_top psd_top_sva i_psd_top_sva (.clk, .resetn, .ser_enable, .pump_up, .pump_down,
   .pump_current_pct, .charge_pump_out_oe, .output_a, .reference_compare_freq,
   .feedback_compare_freq);
`default_nettype wire
